// ===== bench/cpu_addressing_wait_state_ctrl_bench.sv
// self-checking bench for the addressing and wait-state registers
// assumes the package, design files and flash model are compiled first
`default_nettype none
`define CHK(what, exp, got) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("MISMATCH %s exp %h got %h", what, exp, got); \
		end \
	end
module cpu_addressing_wait_state_ctrl_bench
	import addr_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	sfr_req_t    sfr_req = '0;
	logic        sfr_valid = 1'b0;
	logic        ptr_use = 1'b0;
	logic        ptr_inc = 1'b0;
	logic        movx_ri = 1'b0;
	logic        movx_ptr = 1'b0;
	logic        fetch_req = 1'b0;
	logic [7:0]  ri_low = 8'h11;
	logic [7:0]  stack_ptr = 8'h34;
	logic [7:0]  fetch_byte = 8'h00;
	logic [7:0]  flash_data, sfr_rdata, fetch_data, xram_base_page;
	logic        sfr_hit, fetch_ready, wide_mode;
	logic [15:0] stack_addr, vector_base;
	xram_addr_t  xram_out;
	int          errors = 0;
	int          num_checks = 0;

	addr_ctrl_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
		.sfr_valid(sfr_valid), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.ptr_use(ptr_use), .ptr_inc(ptr_inc), .movx_ri(movx_ri), .movx_ptr(movx_ptr),
		.ri_low(ri_low), .stack_ptr(stack_ptr), .fetch_req(fetch_req),
		.flash_data(flash_data), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
		.xram_out(xram_out), .stack_addr(stack_addr), .vector_base(vector_base),
		.wide_mode(wide_mode), .xram_base_page(xram_base_page));

	flash_model u_flash (.core_clk(core_clk), .fetch_req(fetch_req),
		.fetch_byte(fetch_byte), .flash_data(flash_data));

	initial
	begin
		forever #20 core_clk = ~core_clk;
	end

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	task automatic sfr_acc(input logic w, input logic ta, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge core_clk);
		sfr_req <= '{wr: w, ta_open: ta, addr: a, wdata: d};
		sfr_valid <= 1'b1;
		@(posedge core_clk);
		sfr_valid <= 1'b0;
		#1;
	endtask : sfr_acc

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		sfr_acc(1'b1, 1'b1, a, d);
	endtask : sfr_wr

	task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e, input logic h);
		sfr_acc(1'b0, 1'b0, a, 8'h00);
		`CHK("sfr_rdata", e, sfr_rdata)
		`CHK("sfr_hit", h, sfr_hit)
	endtask : sfr_rd

	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	// edges counted from the start edge, ready expected at w+2
	task automatic fetch(input logic [3:0] w, input logic [7:0] b);
		int n;
		n = 0;
		sfr_wr(ADR_WAIT, {4'h0, w});
		@(posedge core_clk);
		fetch_req <= 1'b1;
		fetch_byte <= b;
		while (n < 40 && fetch_ready !== 1'b1)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		`CHK("fetch cycles", int'(w) + 2, n)
		`CHK("fetch_data", b, fetch_data)
		@(posedge core_clk);
		fetch_req <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask : fetch

	task automatic use_ptr(input logic inc);
		@(posedge core_clk);
		ptr_use <= 1'b1;
		ptr_inc <= inc;
		@(posedge core_clk);
		ptr_use <= 1'b0;
		ptr_inc <= 1'b0;
		#1;
	endtask : use_ptr

	task automatic movx(input logic ri, input logic [23:0] e);
		@(posedge core_clk);
		movx_ri <= ri;
		movx_ptr <= ~ri;
		@(posedge core_clk);
		movx_ri <= 1'b0;
		movx_ptr <= 1'b0;
		#1;
		`CHK("xram valid", 1'b1, xram_out.valid)
		`CHK("xram addr", e, xram_out.addr)
	endtask : movx

	initial
	begin
		#200000;
		errors++;
		test_done;
	end

	// the base relocation register is never written: only on-chip xram exists
	initial
	begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		sfr_rd(ADR_WAIT, RST_WAIT, 1'b1);
		sfr_rd(ADR_PTR_LO, 8'h00, 1'b1);
		sfr_rd(ADR_PTR1_LO, 8'h00, 1'b1);
		sfr_rd(ADR_PTR_SEL, 8'h00, 1'b1);
		sfr_rd(ADR_XRAM_BASE, 8'h00, 1'b1);
		sfr_rd(ADR_PAGE_HIGH, 8'h00, 1'b1);
		sfr_rd(ADR_UPPER, 8'h00, 1'b1);
		sfr_rd(8'h00, 8'h00, 1'b0);
		`CHK("base page", 8'h00, xram_base_page)
		sfr_acc(1'b1, 1'b0, ADR_WAIT, 8'h03);
		sfr_rd(ADR_WAIT, RST_WAIT, 1'b1);
		sfr_acc(1'b1, 1'b0, ADR_MODE, 8'h22);
		sfr_rd(ADR_MODE, 8'h00, 1'b1);
		// waits kept above one, as a zero divider needs
		fetch(4'h2, 8'ha5);
		fetch(4'h5, 8'h3c);
		fetch(4'hf, 8'h5a);
		// zero waits: only legal with a nonzero divider, assumed here
		fetch(4'h0, 8'hc3);
		sfr_wr(ADR_STACK_HI, 8'h12);
		sfr_wr(ADR_MODE, 8'h22);
		settle;
		`CHK("wide_mode", 1'b1, wide_mode)
		`CHK("vector_base", 16'h7000, vector_base)
		`CHK("stack_addr", 16'h1234, stack_addr)
		sfr_rd(ADR_MODE, 8'h26, 1'b1);
		sfr_wr(ADR_MODE, 8'h00);
		settle;
		`CHK("wide_mode", 1'b0, wide_mode)
		`CHK("stack_addr", 16'h0034, stack_addr)
		`CHK("vector_base", 16'h0000, vector_base)
		sfr_wr(ADR_UPPER, 8'h5a);
		movx(1'b1, 24'h5aff11);
		sfr_wr(ADR_MODE, 8'h08);
		sfr_wr(ADR_PAGE_HIGH, 8'h3c);
		movx(1'b1, 24'h5a3c11);
		sfr_wr(ADR_PTR_LO, 8'h44);
		sfr_wr(ADR_PTR_HI, 8'h55);
		sfr_wr(ADR_PTR_TOP, 8'h66);
		movx(1'b0, 24'h665544);
		sfr_wr(ADR_PTR1_LO, 8'h77);
		sfr_wr(ADR_PTR1_HI, 8'h88);
		sfr_wr(ADR_PTR1_TOP, 8'h99);
		sfr_wr(ADR_PTR_SEL, 8'h01);
		movx(1'b0, 24'h998877);
		sfr_wr(ADR_PTR_SEL, 8'h20);
		use_ptr(1'b0);
		sfr_rd(ADR_PTR_SEL, 8'h21, 1'b1);
		use_ptr(1'b0);
		sfr_rd(ADR_PTR_SEL, 8'h20, 1'b1);
		sfr_wr(ADR_PTR_SEL, 8'h00);
		use_ptr(1'b1);
		sfr_rd(ADR_PTR_LO, 8'h45, 1'b1);
		sfr_rd(ADR_PTR_SEL, 8'h00, 1'b1);
		sfr_wr(ADR_PTR_SEL, 8'h40);
		use_ptr(1'b1);
		sfr_rd(ADR_PTR_LO, 8'h44, 1'b1);
		sfr_wr(ADR_PTR_SEL, 8'h80);
		use_ptr(1'b1);
		sfr_rd(ADR_PTR_SEL, 8'h81, 1'b1);
		`CHK("base page", 8'h00, xram_base_page)
		test_done;
	end
endmodule : cpu_addressing_wait_state_ctrl_bench
`default_nettype wire

// ===== bench/flash_model.sv
// program flash seen from the fetch port of the register block
// assumes the fetch request is held until the fetch completes
`default_nettype none
module flash_model
(
	// clock
	input  wire logic       core_clk,
	// fetch side
	input  wire logic       fetch_req,
	input  wire logic [7:0] fetch_byte,
	// data to the block
	output var  logic [7:0] flash_data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial flash_data = 8'h00;

	// outside a fetch the byte flips every cycle so a stale capture shows
	always_ff @(posedge core_clk)
	begin
		if (fetch_req)
			flash_data <= fetch_byte;
		else
			flash_data <= ~flash_data;
	end
endmodule : flash_model
`default_nettype wire

// ===== hw/addr_ctrl_regs.sv
// addressing mode, wait-state and dual data pointer registers
// assumes the cpu presents sfr accesses one cycle each and decodes its own
// instructions into the ptr_use / ptr_inc and movx strobes below
`default_nettype none

module addr_ctrl_regs
	import addr_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// sfr access from the cpu
	input  wire sfr_req_t    sfr_req,
	input  wire logic        sfr_valid,
	output logic [7:0]       sfr_rdata,
	output logic             sfr_hit,
	// instruction side events
	input  wire logic        ptr_use,
	input  wire logic        ptr_inc,
	input  wire logic        movx_ri,
	input  wire logic        movx_ptr,
	input  wire logic [7:0]  ri_low,
	input  wire logic [7:0]  stack_ptr,
	// flash fetch
	input  wire logic        fetch_req,
	input  wire logic [7:0]  flash_data,
	output logic             fetch_ready,
	output logic [7:0]       fetch_data,
	// address outputs
	output xram_addr_t       xram_out,
	output logic [15:0]      stack_addr,
	output logic [15:0]      vector_base,
	output logic             wide_mode,
	output logic [7:0]       xram_base_page
);
	logic [7:0]  flash_wait_cycles;
	logic [7:0]  xram_base_relocation;
	logic [7:0]  addressing_mode_ctrl;
	logic [7:0]  pointer_select_ctrl;
	logic [7:0]  indirect_page_high;
	logic [7:0]  indirect_upper_address;
	logic [7:0]  stack_high_byte;
	logic [7:0]  port_two_latch;
	logic [23:0] primary_pointer;
	logic [23:0] secondary_pointer;
	logic        wr;
	logic        sel;
	logic [1:0]  increment_mode;
	logic        auto_toggle_enable;
	logic        next_sel;
	logic [7:0]  rd_mux;
	logic        rd_hit;

	assign wr                 = sfr_valid && sfr_req.wr;
	assign sel                = pointer_select_ctrl[SEL_BIT];
	assign auto_toggle_enable = pointer_select_ctrl[SEL_TSL];
	assign increment_mode     = {pointer_select_ctrl[SEL_ID1], pointer_select_ctrl[SEL_ID0]};

	// protected registers: writes dropped while the guard is closed
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flash_wait_cycles    <= RST_WAIT;
			xram_base_relocation <= RST_ZERO;
			addressing_mode_ctrl <= RST_ZERO;
		end
		else if (wr && sfr_req.ta_open)
		begin
			if (sfr_req.addr == ADR_WAIT)
				flash_wait_cycles <= {4'h0, sfr_req.wdata[WAIT_MSB:0]};
			if (sfr_req.addr == ADR_XRAM_BASE)
				xram_base_relocation <= sfr_req.wdata;
			if (sfr_req.addr == ADR_MODE)
				addressing_mode_ctrl <= sfr_req.wdata & MODE_MASK;
		end
	end

	// plain registers
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			indirect_page_high     <= RST_ZERO;
			indirect_upper_address <= RST_ZERO;
			stack_high_byte        <= RST_ZERO;
			port_two_latch         <= RST_PORT_TWO;
		end
		else if (wr)
		begin
			if (sfr_req.addr == ADR_PAGE_HIGH)
				indirect_page_high <= sfr_req.wdata;
			if (sfr_req.addr == ADR_UPPER)
				indirect_upper_address <= sfr_req.wdata;
			if (sfr_req.addr == ADR_STACK_HI)
				stack_high_byte <= sfr_req.wdata;
			if (sfr_req.addr == ADR_PORT_TWO)
				port_two_latch <= sfr_req.wdata;
		end
	end

	// selection after a pointer use: toggle, or id mode 1x also flips on an increment
	always_comb
	begin
		next_sel = sel;
		if (ptr_use && (auto_toggle_enable || (ptr_inc && increment_mode[1])))
			next_sel = ~sel;
	end

	// a software write of the select register wins over a same-cycle use
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			pointer_select_ctrl <= RST_ZERO;
		else if (wr && sfr_req.addr == ADR_PTR_SEL)
			pointer_select_ctrl <= sfr_req.wdata & SEL_MASK;
		else
			pointer_select_ctrl[SEL_BIT] <= next_sel;
	end

	// id0 set turns increment into decrement
	pointer_pair u_primary (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.wr_lo    (wr && sfr_req.addr == ADR_PTR_LO),
		.wr_hi    (wr && sfr_req.addr == ADR_PTR_HI),
		.wr_top   (wr && sfr_req.addr == ADR_PTR_TOP),
		.wdata    (sfr_req.wdata),
		.step     (ptr_inc && !sel),
		.down     (increment_mode[0]),
		.value    (primary_pointer)
	);

	pointer_pair u_secondary (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.wr_lo    (wr && sfr_req.addr == ADR_PTR1_LO),
		.wr_hi    (wr && sfr_req.addr == ADR_PTR1_HI),
		.wr_top   (wr && sfr_req.addr == ADR_PTR1_TOP),
		.wdata    (sfr_req.wdata),
		.step     (ptr_inc && sel),
		.down     (increment_mode[0]),
		.value    (secondary_pointer)
	);

	wait_counter #(.W(WAIT_MSB + 1)) u_wait (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.wait_cycles (flash_wait_cycles[WAIT_MSB:0]),
		.fetch_req   (fetch_req),
		.flash_data  (flash_data),
		.fetch_ready (fetch_ready),
		.fetch_data  (fetch_data)
	);

	// read mux; stack indicator follows the wide-mode bit
	always_comb
	begin
		rd_hit = 1'b1;
		case (sfr_req.addr)
			ADR_PTR_LO:    rd_mux = primary_pointer[7:0];
			ADR_PTR_HI:    rd_mux = primary_pointer[15:8];
			ADR_PTR1_LO:   rd_mux = secondary_pointer[7:0];
			ADR_PTR1_HI:   rd_mux = secondary_pointer[15:8];
			ADR_PTR_SEL:   rd_mux = pointer_select_ctrl;
			ADR_WAIT:      rd_mux = flash_wait_cycles;
			ADR_PTR_TOP:   rd_mux = primary_pointer[23:16];
			ADR_PTR1_TOP:  rd_mux = secondary_pointer[23:16];
			ADR_STACK_HI:  rd_mux = stack_high_byte;
			ADR_MODE:      rd_mux = {addressing_mode_ctrl[7:3],
				addressing_mode_ctrl[MODE_HI], addressing_mode_ctrl[1:0]};
			ADR_PORT_TWO:  rd_mux = port_two_latch;
			ADR_XRAM_BASE: rd_mux = xram_base_relocation;
			ADR_PAGE_HIGH: rd_mux = indirect_page_high;
			ADR_UPPER:     rd_mux = indirect_upper_address;
			default:
			begin
				rd_mux = RST_ZERO;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sfr_rdata <= RST_ZERO;
			sfr_hit   <= 1'b0;
		end
		else
		begin
			sfr_rdata <= (sfr_valid && !sfr_req.wr) ? rd_mux : RST_ZERO;
			sfr_hit   <= sfr_valid && rd_hit;
		end
	end

	// external data address; top bytes carried but not decoded by memory
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			xram_out <= '0;
		else
		begin
			xram_out.valid <= movx_ri || movx_ptr;
			if (movx_ptr)
				xram_out.addr <= sel ? secondary_pointer : primary_pointer;
			else if (movx_ri)
				xram_out.addr <= {indirect_upper_address,
					addressing_mode_ctrl[MODE_SRC] ? indirect_page_high : port_two_latch,
					ri_low};
		end
	end

	// mode-derived outputs and the relocated xram base page
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wide_mode      <= 1'b0;
			stack_addr     <= '0;
			vector_base    <= VEC_LOW_BASE;
			xram_base_page <= RST_ZERO;
		end
		else
		begin
			wide_mode   <= addressing_mode_ctrl[MODE_HI];
			stack_addr  <= addressing_mode_ctrl[MODE_HI] ?
				{stack_high_byte, stack_ptr} : {8'h00, stack_ptr};
			vector_base <= addressing_mode_ctrl[MODE_VEC] ?
				{VEC_HI_NIBBLE, XRAM_STEP_ZERO} : VEC_LOW_BASE;
			xram_base_page <= xram_base_relocation;
		end
	end

	a_guard_blocks: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr && !sfr_req.ta_open && sfr_req.addr == ADR_WAIT) |=> $stable(flash_wait_cycles))
		else $error("wait register changed without timed access");
	a_toggle_flip: assert property (@(posedge core_clk) disable iff (sys_rst)
		(ptr_use && auto_toggle_enable && !(wr && sfr_req.addr == ADR_PTR_SEL))
		|=> sel != $past(sel))
		else $error("pointer select did not toggle");
	a_ri_source: assert property (@(posedge core_clk) disable iff (sys_rst)
		(movx_ri && !movx_ptr && addressing_mode_ctrl[MODE_SRC])
		|=> xram_out.addr[15:8] == $past(indirect_page_high))
		else $error("indirect high byte from wrong source");
	a_ri_upper: assert property (@(posedge core_clk) disable iff (sys_rst)
		(movx_ri && !movx_ptr) |=> xram_out.addr[23:16] == $past(indirect_upper_address))
		else $error("indirect upper byte wrong");
	a_ptr_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
		(movx_ptr && !sel) |=> xram_out.addr == $past(primary_pointer))
		else $error("pointer move address wrong");
	a_vector_base: assert property (@(posedge core_clk) disable iff (sys_rst)
		addressing_mode_ctrl[MODE_VEC] ##1 addressing_mode_ctrl[MODE_VEC]
		|-> vector_base == 16'h7000)
		else $error("vector base not relocated");
	a_stack_wide: assert property (@(posedge core_clk) disable iff (sys_rst)
		addressing_mode_ctrl[MODE_HI]
		|=> stack_addr == {$past(stack_high_byte), $past(stack_ptr)})
		else $error("wide stack address wrong");
	a_ri_port_two: assert property (@(posedge core_clk) disable iff (sys_rst)
		(movx_ri && !movx_ptr && !addressing_mode_ctrl[MODE_SRC])
		|=> xram_out.addr[15:8] == $past(port_two_latch))
		else $error("indirect high byte not from port two");
	a_ptr_second: assert property (@(posedge core_clk) disable iff (sys_rst)
		(movx_ptr && sel) |=> xram_out.addr == $past(secondary_pointer))
		else $error("second pointer move address wrong");
	a_move_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
		!(movx_ri || movx_ptr) |=> !xram_out.valid)
		else $error("move address valid without a move");
	a_vector_low: assert property (@(posedge core_clk) disable iff (sys_rst)
		!addressing_mode_ctrl[MODE_VEC] ##1 !addressing_mode_ctrl[MODE_VEC]
		|-> vector_base == VEC_LOW_BASE)
		else $error("vector base not at low region");
	a_mode_guard: assert property (@(posedge core_clk) disable iff (sys_rst)
		(wr && !sfr_req.ta_open && sfr_req.addr == ADR_MODE)
		|=> $stable(addressing_mode_ctrl))
		else $error("mode register changed without timed access");
	a_sel_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!ptr_use && !(wr && sfr_req.addr == ADR_PTR_SEL)) |=> $stable(sel))
		else $error("pointer select changed without a use");
	a_wait_reset: assert property (@(posedge core_clk)
		$fell(sys_rst) |-> flash_wait_cycles == RST_WAIT)
		else $error("wait register reset value wrong");
endmodule : addr_ctrl_regs
`default_nettype wire

// ===== hw/pointer_pair.sv
// one data pointer: low, high and top byte registers
// assumes the sfr decoder raises one write strobe per byte
`default_nettype none
module pointer_pair
	import addr_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// writes
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic        wr_top,
	input  wire logic [7:0]  wdata,
	// pointer update
	input  wire logic        step,
	input  wire logic        down,
	// value
	output logic [23:0]      value
);
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			value <= '0;
		else if (wr_lo)
			value[7:0] <= wdata;
		else if (wr_hi)
			value[15:8] <= wdata;
		else if (wr_top)
			value[23:16] <= wdata;
		else if (step)
			value[15:0] <= down ? value[15:0] - 16'h0001 : value[15:0] + 16'h0001;
	end
endmodule : pointer_pair
`default_nettype wire

// ===== hw/wait_counter.sv
// flash fetch wait-state counter
// assumes fetch_req is held until fetch_ready
`default_nettype none
module wait_counter
	import addr_ctrl_pkg::*;
#(
	parameter int W = 4
)(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// control
	input  wire logic [W-1:0] wait_cycles,
	input  wire logic         fetch_req,
	input  wire logic [7:0]   flash_data,
	// result
	output logic              fetch_ready,
	output logic [7:0]        fetch_data
);
	logic [W-1:0] count;
	logic         busy;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count       <= '0;
			busy        <= 1'b0;
			fetch_ready <= 1'b0;
			fetch_data  <= RST_ZERO;
		end
		else
		begin
			fetch_ready <= 1'b0;
			if (fetch_req && !busy && !fetch_ready)
			begin
				busy  <= 1'b1;
				count <= wait_cycles;
			end
			else if (busy && count != '0)
				count <= count - 1'b1;
			else if (busy)
			begin
				busy        <= 1'b0;
				fetch_ready <= 1'b1;
				fetch_data  <= flash_data;
			end
		end
	end

	// independent span count, so the stall length is checked for every wait setting
	logic [W:0]   span;
	logic [W-1:0] taken_wait;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			span       <= '0;
			taken_wait <= '0;
		end
		else if (fetch_req && !busy && !fetch_ready)
		begin
			span       <= '0;
			taken_wait <= wait_cycles;
		end
		else if (busy)
			span <= span + 1'b1;
	end

	a_wait_count: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(fetch_ready) |-> span == {1'b0, taken_wait} + 1'b1)
		else $error("fetch stall length wrong");

	// start to ready spans wait_cycles+2 edges
	a_wait_exact: assert property (@(posedge core_clk) disable iff (sys_rst)
		(fetch_req && !busy && !fetch_ready && wait_cycles == '0) |=> ##1 fetch_ready)
		else $error("zero-wait fetch not ready on time");
endmodule : wait_counter
`default_nettype wire

// ===== pkg/addr_ctrl_pkg.sv
// addressing and wait-state control constants and carriers
// assumes an 8-bit special-function register space on the cpu clock
`default_nettype none
package addr_ctrl_pkg;
	localparam logic [7:0] ADR_PTR_LO     = 8'h82;
	localparam logic [7:0] ADR_PTR_HI     = 8'h83;
	localparam logic [7:0] ADR_PTR1_LO    = 8'h84;
	localparam logic [7:0] ADR_PTR1_HI    = 8'h85;
	localparam logic [7:0] ADR_PTR_SEL    = 8'h86;
	localparam logic [7:0] ADR_WAIT       = 8'h92;
	localparam logic [7:0] ADR_PTR_TOP    = 8'h93;
	localparam logic [7:0] ADR_PTR1_TOP   = 8'h95;
	localparam logic [7:0] ADR_STACK_HI   = 8'h9b;
	localparam logic [7:0] ADR_MODE       = 8'h9d;
	localparam logic [7:0] ADR_PORT_TWO   = 8'ha0;
	localparam logic [7:0] ADR_XRAM_BASE  = 8'hc6;
	localparam logic [7:0] ADR_PAGE_HIGH  = 8'hda;
	localparam logic [7:0] ADR_UPPER      = 8'hea;

	localparam logic [7:0] RST_WAIT       = 8'h07;
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_PORT_TWO   = 8'hff;

	// field positions
	localparam int WAIT_MSB  = 3;
	localparam int MODE_HI   = 1;
	localparam int MODE_SA   = 2;
	localparam int MODE_SRC  = 3;
	localparam int MODE_VEC  = 5;
	localparam int SEL_BIT   = 0;
	localparam int SEL_TSL   = 5;
	localparam int SEL_ID0   = 6;
	localparam int SEL_ID1   = 7;
	localparam logic [7:0] MODE_MASK = 8'h2b;
	localparam logic [7:0] SEL_MASK  = 8'he1;
	localparam logic [11:0] XRAM_STEP_ZERO = 12'h000;
	localparam logic [3:0]  VEC_HI_NIBBLE  = 4'h7;
	localparam logic [15:0] VEC_LOW_BASE   = 16'h0000;

	typedef struct packed {
		logic       wr;
		logic       ta_open;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic [23:0] addr;
		logic        valid;
	} xram_addr_t;
endpackage : addr_ctrl_pkg
`default_nettype wire
